// [hdl/rsp_port.sv]
// Redundant serial register port, device end
//
// Summary of operation
// - A frame has exactly 64 clocks; any other length is flagged, and a write of it is dropped.
// - Status byte follows, bit 7 first: parity, ovf, unf, dpar, mismatch, -, clk, addr.
// - Status reports the previous frame, including its own parity bit.
// - Last 32 bits carry the data word, MSB first, either direction.
// - Data parity covers only the data word moved.
// - Setting mismatch sets its flag and suppresses any access.
// - Extra clocks on a read give zeros and an error in status.
// - Extra clocks on a write abandon the write and flag an error.
// - Bad clock count flag set when clock count differed from 64.
// - Bad address flag set for blocked or refused accesses.
// - Select high holds the port idle, output undriven, inputs ignored.
// - Reception starts on first serial clock rise after select falls.
// - Safe mode blocks all writes except to the word holding it.
// - Pin reset or reset pattern write halts, clears and starts loading.
// - Load engine fills static state; host loads everything else.
// - Load engine refreshes one managed register per second.
// - Unexpected reset sets a flag and holds interrupt low until cleared.
// - DIO pins undriven after reset until individually configured.
// - Supply code: 00 good, 01 between thresholds, 11 below low.
// - Interrupt marks end of each accumulation cycle.
`timescale 1ns/1ps
`default_nettype none
`include "rsp_consts.svh"

module rsp_port #(
    parameter int unsigned REFRESH_CYC = `RSP_REFRESH_CYC
) (
    // Clock and reset
    input  wire logic             MCLK_I,
    input  wire logic             ARST_N_I,
    // Serial link
    input  wire logic             PORT_SELECT_N_I,
    input  wire logic             PORT_SCLK_I,
    input  wire logic             PORT_SERIAL_IN_I,
    output var  logic             PORT_SDO_O,
    output var  logic             PORT_SDO_OE_O,
    // Register read
    output var  logic             RD_REQ_O,
    output var  logic [10:0]      RD_ADDR_O,
    input  wire logic             RD_VALID_I,
    input  wire logic [31:0]      RD_DATA_I,
    input  wire logic             RD_ERR_I,
    // Register write
    output var  logic             WR_VALID_O,
    input  wire logic             WR_READY_I,
    output var  rsp_pkg::rsp_wr_t WR_O,
    // System
    input  wire logic             ACC_DONE_I,
    input  wire logic             SUPPLY_WARN_I,
    input  wire logic             SUPPLY_LOW_I,
    output var  logic             INT_N_O,
    output var  logic             SOFT_RESET_O,
    output var  logic             LOAD_START_O,
    output var  logic             REFRESH_TICK_O,
    output var  logic [1:0]       SUPPLY_LEVEL_CODE_O,
    output var  logic [3:0]       DIO_OE_O,
    output var  logic [3:0]       DIO_OUT_O
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic s_sel1, s_sel2, s_sel3;
    logic s_ck1, s_ck2, s_ck3;
    logic s_di1, s_di2;
    logic s_warn1, s_warn2;
    logic s_low1, s_low2;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            {s_sel1, s_sel2, s_sel3} <= 3'h7;
            {s_ck1, s_ck2, s_ck3}    <= 3'h0;
            {s_di1, s_di2}           <= 2'h0;
            {s_warn1, s_warn2}       <= 2'h0;
            {s_low1, s_low2}         <= 2'h0;
        end else begin
            {s_sel1, s_sel2, s_sel3} <= {PORT_SELECT_N_I, s_sel1, s_sel2};
            {s_ck1, s_ck2, s_ck3}    <= {PORT_SCLK_I, s_ck1, s_ck2};
            {s_di1, s_di2}           <= {PORT_SERIAL_IN_I, s_di1};
            {s_warn1, s_warn2}       <= {SUPPLY_WARN_I, s_warn1};
            {s_low1, s_low2}         <= {SUPPLY_LOW_I, s_low1};
        end
    end

    logic active;
    logic rise;
    logic fall;
    logic frame_end;

    assign active    = !s_sel2;
    assign rise      = active && s_ck2 && !s_ck3;
    assign fall      = active && !s_ck2 && s_ck3;
    assign frame_end = s_sel2 && !s_sel3;

    // ************************************************************
    // Frame reception
    // ************************************************************
    logic [6:0]  cnt;
    logic [31:0] sh;
    logic [31:0] next_sh;
    logic [10:0] adr;
    logic        dir;
    logic        mis;
    logic        set_ok;

    assign next_sh = {sh[30:0], s_di2};
    assign set_ok  = (next_sh[23:13] == ~next_sh[11:1])
                  && (next_sh[12] == ~next_sh[0]);

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cnt <= 7'h00;
            sh  <= 32'h00000000;
            adr <= 11'h000;
            dir <= 1'b0;
            mis <= 1'b0;
        end else if (!active) begin
            cnt <= 7'h00;
        end else if (rise) begin
            sh <= next_sh;
            if (cnt != `RSP_CNT_MAX) begin
                cnt <= cnt + 7'h01;
            end
            if (cnt == `RSP_SET_LAST) begin
                adr <= next_sh[23:13];
                dir <= next_sh[12];
                mis <= !set_ok;
            end
        end
    end

    // ************************************************************
    // Local registers and read fetch
    // ************************************************************
    logic        fres;
    logic        acc;
    logic        safe;
    logic [7:0]  dio;
    logic [31:0] mstat_val;
    logic [31:0] ctrl_val;
    logic [31:0] loc_val;
    logic [10:0] rd_adr;
    logic        rd_loc;

    assign mstat_val = {26'h0, SUPPLY_LEVEL_CODE_O, 2'h0, acc, fres};
    assign ctrl_val  = {23'h0, safe, dio};
    assign rd_adr    = next_sh[23:13];
    assign rd_loc    = (rd_adr == `RSP_ADDR_MSTAT) || (rd_adr == `RSP_ADDR_CTRL)
                    || (rd_adr == `RSP_ADDR_RESET);

    always_comb begin
        loc_val = 32'h00000000;
        if (rd_adr == `RSP_ADDR_MSTAT) begin
            loc_val = mstat_val;
        end else if (rd_adr == `RSP_ADDR_CTRL) begin
            loc_val = ctrl_val;
        end
    end

    rsp_pkg::rsp_rd_t rd_st;
    logic [31:0]      rdat;
    logic             rerr;
    logic             unf;
    logic             rd_have;

    assign rd_have = (rd_st == rsp_pkg::RSP_RD_HAVE);

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rd_st     <= rsp_pkg::RSP_RD_NONE;
            RD_REQ_O  <= 1'b0;
            RD_ADDR_O <= 11'h000;
            rdat      <= 32'h00000000;
            rerr      <= 1'b0;
        end else if (!active) begin
            rd_st    <= rsp_pkg::RSP_RD_NONE;
            RD_REQ_O <= 1'b0;
        end else begin
            RD_REQ_O <= 1'b0;
            unique case (rd_st)
                rsp_pkg::RSP_RD_NONE: begin
                    if (rise && cnt == `RSP_SET_LAST && set_ok && next_sh[12]) begin
                        if (rd_loc) begin
                            rdat  <= loc_val;
                            rerr  <= 1'b0;
                            rd_st <= rsp_pkg::RSP_RD_HAVE;
                        end else begin
                            RD_REQ_O  <= 1'b1;
                            RD_ADDR_O <= rd_adr;
                            rd_st     <= rsp_pkg::RSP_RD_WAIT;
                        end
                    end
                end
                rsp_pkg::RSP_RD_WAIT: begin
                    if (RD_VALID_I) begin
                        rdat  <= RD_DATA_I;
                        rerr  <= RD_ERR_I;
                        rd_st <= rsp_pkg::RSP_RD_HAVE;
                    end
                end
                rsp_pkg::RSP_RD_HAVE: begin
                end
            endcase
        end
    end

    // Read word missing when the data phase begins
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            unf <= 1'b0;
        end else if (!active) begin
            unf <= 1'b0;
        end else if (rise && cnt == `RSP_DATA_FIRST - 7'h01 && dir && !mis && !rd_have) begin
            unf <= 1'b1;
        end
    end

    // ************************************************************
    // Serial output
    // ************************************************************
    rsp_pkg::rsp_stat_t st;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PORT_SDO_O    <= 1'b0;
            PORT_SDO_OE_O <= 1'b0;
        end else begin
            PORT_SDO_OE_O <= active;
            if (!active) begin
                PORT_SDO_O <= 1'b0;
            end else if (fall) begin
                if (cnt >= `RSP_STAT_FIRST && cnt < `RSP_DATA_FIRST) begin
                    PORT_SDO_O <= st[~cnt[2:0]];
                end else if (cnt >= `RSP_DATA_FIRST && cnt < `RSP_FRAME_BITS
                             && dir && !mis && !unf && rd_have) begin
                    PORT_SDO_O <= rdat[~cnt[4:0]];
                end else begin
                    PORT_SDO_O <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Frame end: status and write commit
    // ************************************************************
    logic               len_ok;
    logic               set_seen;
    logic               wr_ok;
    logic               wr_blk;
    logic               wr_loc;
    logic               fifo_rdy;
    logic               soft_cmd;
    logic               wr_push;
    rsp_pkg::rsp_wr_t   wr_word;
    rsp_pkg::rsp_stat_t next_st;

    assign len_ok   = (cnt == `RSP_FRAME_BITS);
    assign set_seen = (cnt > `RSP_SET_LAST);
    assign wr_ok    = frame_end && len_ok && !mis && !dir;
    assign wr_blk   = safe && (adr != `RSP_ADDR_CTRL);
    assign wr_loc   = (adr == `RSP_ADDR_MSTAT) || (adr == `RSP_ADDR_CTRL)
                   || (adr == `RSP_ADDR_RESET);
    assign soft_cmd = wr_ok && !wr_blk && adr == `RSP_ADDR_RESET
                   && sh == `RSP_RESET_PATTERN;

    always_comb begin
        next_st         = st;
        next_st.badclk  = !len_ok;
        next_st.mis     = set_seen && mis;
        next_st.unf     = unf;
        next_st.dpar    = dir ? (rd_have && !unf && ^rdat) : ^sh;
        next_st.ovf     = wr_ok && !wr_blk && !wr_loc && !fifo_rdy;
        next_st.rsvd    = 1'b0;
        next_st.badaddr = set_seen && !mis
                       && (dir ? (rd_have && rerr) : (len_ok && wr_blk));
        next_st.spar    = ^{next_st.ovf, next_st.unf, next_st.dpar, next_st.mis,
                            next_st.rsvd, next_st.badclk, next_st.badaddr};
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st <= '0;
        end else if (frame_end) begin
            st <= next_st;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_push <= 1'b0;
            wr_word <= '0;
        end else begin
            wr_push <= wr_ok && !wr_blk && !wr_loc && fifo_rdy;
            wr_word <= '{addr: adr, data: sh};
        end
    end

    rsp_fifo2 #(
        .W($bits(rsp_pkg::rsp_wr_t))
    ) u_buf (
        .clk_i      (MCLK_I),
        .arst_n_i   (ARST_N_I),
        .in_valid_i (wr_push),
        .in_ready_o (fifo_rdy),
        .in_data_i  (wr_word),
        .out_valid_o(WR_VALID_O),
        .out_ready_i(WR_READY_I),
        .out_data_o (WR_O)
    );

    // ************************************************************
    // Control, status and reset handling
    // ************************************************************
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            safe <= 1'b0;
            dio  <= `RSP_DIO_RESET;
        end else if (soft_cmd) begin
            safe <= 1'b0;
            dio  <= `RSP_DIO_RESET;
        end else if (wr_ok && !wr_blk && adr == `RSP_ADDR_CTRL) begin
            safe <= sh[`RSP_CTRL_SAFE];
            dio  <= sh[7:0];
        end
    end

    // Pin reset is never expected; host clears by writing one
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fres <= 1'b1;
        end else if (wr_ok && !wr_blk && adr == `RSP_ADDR_MSTAT
                     && sh[`RSP_MSTAT_FRESET]) begin
            fres <= 1'b0;
        end
    end

    // Accumulation end flag, a new event beats the clear
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            acc <= 1'b0;
        end else if (ACC_DONE_I) begin
            acc <= 1'b1;
        end else if (wr_ok && !wr_blk && adr == `RSP_ADDR_MSTAT
                     && sh[`RSP_MSTAT_ACC]) begin
            acc <= 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            INT_N_O <= 1'b0;
        end else begin
            INT_N_O <= !(fres || acc);
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SOFT_RESET_O <= 1'b0;
            LOAD_START_O <= 1'b1;
        end else begin
            SOFT_RESET_O <= soft_cmd;
            LOAD_START_O <= soft_cmd;
        end
    end

    // One managed register refreshed per period
    logic [31:0] rcnt;
    logic        rtick;

    assign rtick = (rcnt == REFRESH_CYC - 1);

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rcnt           <= 32'h00000000;
            REFRESH_TICK_O <= 1'b0;
        end else begin
            REFRESH_TICK_O <= rtick && !soft_cmd;
            if (soft_cmd || rtick) begin
                rcnt <= 32'h00000000;
            end else begin
                rcnt <= rcnt + 32'h00000001;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SUPPLY_LEVEL_CODE_O <= `RSP_SUP_OK;
            DIO_OE_O            <= 4'h0;
            DIO_OUT_O           <= 4'h0;
        end else begin
            SUPPLY_LEVEL_CODE_O <= s_low2 ? `RSP_SUP_LOW
                                 : s_warn2 ? `RSP_SUP_WARN : `RSP_SUP_OK;
            for (int i = 0; i < 4; i++) begin
                DIO_OE_O[i]  <= dio[2*i+1];
                DIO_OUT_O[i] <= dio[2*i];
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    property p_oe_idle;
        s_sel2 |=> !PORT_SDO_OE_O && cnt == 7'h00;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("port active while deselected");

    property p_badclk;
        frame_end && cnt != `RSP_FRAME_BITS |=> st.badclk && st.spar == ^st[6:0];
    endproperty
    a_badclk: assert property (p_badclk) else $error("bad clock count not flagged");

    property p_len_nowr;
        frame_end && cnt != `RSP_FRAME_BITS |=> !wr_push [*2];
    endproperty
    a_len_nowr: assert property (p_len_nowr) else $error("write of bad length frame");

    property p_mis;
        rise && cnt == `RSP_SET_LAST && !set_ok |=> !RD_REQ_O [*4];
    endproperty
    a_mis: assert property (p_mis) else $error("access after setting mismatch");

    property p_safe;
        wr_push |-> !safe;
    endproperty
    a_safe: assert property (p_safe) else $error("write passed safe mode");

    property p_tail;
        fall && cnt >= `RSP_FRAME_BITS |=> !PORT_SDO_O;
    endproperty
    a_tail: assert property (p_tail) else $error("data beyond frame end");

    property p_int;
        fres |=> !INT_N_O;
    endproperty
    a_int: assert property (p_int) else $error("reset event not signalled");

    property p_acc;
        ACC_DONE_I |-> ##2 !INT_N_O;
    endproperty
    a_acc: assert property (p_acc) else $error("accumulation end not signalled");

    property p_sup;
        s_low2 |=> SUPPLY_LEVEL_CODE_O == `RSP_SUP_LOW;
    endproperty
    a_sup: assert property (p_sup) else $error("supply code wrong");

endmodule : rsp_port

`default_nettype wire

// [hdl/rsp_consts.svh]
// Constants of the redundant serial register port
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

// Frame layout, in clocked bits
`define RSP_FRAME_BITS    7'h40
`define RSP_SET_LAST      7'h17
`define RSP_STAT_FIRST    7'h18
`define RSP_DATA_FIRST    7'h20
`define RSP_CNT_MAX       7'h7F

// Word addresses
`define RSP_ADDR_MSTAT    11'h320
`define RSP_ADDR_CTRL     11'h321
`define RSP_ADDR_RESET    11'h322

// Reset pattern, arbitrary value
`define RSP_RESET_PATTERN 32'hA55A5AA5

// Main status fields
`define RSP_MSTAT_FRESET  0
`define RSP_MSTAT_ACC     1
`define RSP_MSTAT_SUP_LO  4

// Control fields
`define RSP_CTRL_SAFE     8
`define RSP_DIO_RESET     8'h00

// Supply level codes
`define RSP_SUP_OK        2'h0
`define RSP_SUP_WARN      2'h1
`define RSP_SUP_LOW       2'h3

// Load engine refresh period
`define RSP_CLK_HZ        20000000
`define RSP_REFRESH_MS    1000
`define RSP_REFRESH_CYC   (`RSP_CLK_HZ / 1000 * `RSP_REFRESH_MS)

`endif

// [hdl/rsp_pkg.sv]
// Types of the redundant serial register port
package rsp_pkg;

    typedef struct packed {
        logic [10:0] addr;
        logic [31:0] data;
    } rsp_wr_t;

    typedef struct packed {
        logic spar;
        logic ovf;
        logic unf;
        logic dpar;
        logic mis;
        logic rsvd;
        logic badclk;
        logic badaddr;
    } rsp_stat_t;

    typedef enum logic [1:0] {
        RSP_RD_NONE,
        RSP_RD_WAIT,
        RSP_RD_HAVE
    } rsp_rd_t;

endpackage : rsp_pkg

// [hdl/rsp_fifo2.sv]
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module rsp_fifo2 #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    // Fill side
    input  wire logic         in_valid_i,
    output var  logic         in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output var  logic         out_valid_o,
    input  wire logic         out_ready_i,
    output var  logic [W-1:0] out_data_o
);

    logic         tail_v;
    logic [W-1:0] tail;
    logic         push;
    logic         pop;

    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    // Head is the oldest word, tail the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
            tail_v      <= 1'b0;
            tail        <= '0;
            in_ready_o  <= 1'b1;
        end else begin
            if (pop) begin
                if (tail_v) begin
                    out_data_o <= tail;
                    tail_v     <= push;
                    in_ready_o <= !push;
                    if (push) begin
                        tail <= in_data_i;
                    end
                end else begin
                    out_valid_o <= push;
                    if (push) begin
                        out_data_o <= in_data_i;
                    end
                end
            end else if (push) begin
                if (!out_valid_o) begin
                    out_valid_o <= 1'b1;
                    out_data_o  <= in_data_i;
                end else begin
                    tail_v     <= 1'b1;
                    tail       <= in_data_i;
                    in_ready_o <= 1'b0;
                end
            end
        end
    end

endmodule : rsp_fifo2

`default_nettype wire

// [verification/rsp_host.sv]
// Host side model of the redundant serial register port
`timescale 1ns/1ps
`default_nettype none

module rsp_host (
    // Clock
    input  wire logic clk_i,
    // Serial link
    output var  logic sel_n_o,
    output var  logic sclk_o,
    output var  logic sdi_o,
    input  wire logic sdo_i,
    input  wire logic oe_i
);
    logic lst = 1'b0;
    logic line;

    // Released line shows a changing pattern
    assign line = oe_i ? sdo_i : ~lst;

    always @(posedge clk_i) lst <= line;

    initial begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        sdi_o   = 1'b0;
    end

    // One frame of n clocks, sampled before each of the first 64 falls
    task automatic frame(input logic [10:0] a, input logic rd, input logic [31:0] d,
                         input int n, input logic bad, output logic [63:0] r);
        logic [63:0] v;
        v = {a, rd, ~a ^ {10'h0, bad}, ~rd, 8'h00, d};
        r = 64'h0;
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            sdi_o <= (i < 64) ? v[63-i] : 1'b0;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            if (i < 64) r[63-i] = line;
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        sel_n_o <= 1'b1;
    endtask : frame
endmodule : rsp_host

`default_nettype wire

// [verification/tb_top.sv]
// Testbench of the redundant serial register port
`timescale 1ns/1ps
`default_nettype none
`include "rsp_consts.svh"

module tb_top;
    logic             clk      = 1'b0;
    logic             arst_n   = 1'b0;
    logic             rd_valid = 1'b0;
    logic [31:0]      rd_data  = 32'h0;
    logic             acc      = 1'b0;
    logic             warn     = 1'b0;
    logic             low      = 1'b0;
    logic             rd_err   = 1'b0;
    logic             wr_rdy   = 1'b1;
    logic             sel_n, sclk, sdi, sdo, oe, rd_req, wr_valid, int_n, srst, ref_p, ls;
    logic [10:0]      rd_addr;
    logic [1:0]       code;
    logic [3:0]       dio_oe, dio_out;
    logic [7:0]       st;
    logic [31:0]      q;
    rsp_pkg::rsp_wr_t wr, last_wr, lw;
    int               nwr = 0, nsr = 0, nref = 0, nls = 0, snap;
    int               failures = 0, n_tests = 0;
    int               lens[4] = '{40, 66, 66, 64};
    logic [1:0]       sup[3] = '{2'h0, 2'h1, 2'h3};

    always #25 clk = ~clk;

    rsp_port #(.REFRESH_CYC(50)) i_rsp_port (
        .MCLK_I(clk), .ARST_N_I(arst_n),
        .PORT_SELECT_N_I(sel_n), .PORT_SCLK_I(sclk), .PORT_SERIAL_IN_I(sdi),
        .PORT_SDO_O(sdo), .PORT_SDO_OE_O(oe),
        .RD_REQ_O(rd_req), .RD_ADDR_O(rd_addr), .RD_VALID_I(rd_valid),
        .RD_DATA_I(rd_data), .RD_ERR_I(rd_err),
        .WR_VALID_O(wr_valid), .WR_READY_I(wr_rdy), .WR_O(wr),
        .ACC_DONE_I(acc), .SUPPLY_WARN_I(warn), .SUPPLY_LOW_I(low),
        .INT_N_O(int_n), .SOFT_RESET_O(srst), .LOAD_START_O(ls),
        .REFRESH_TICK_O(ref_p), .SUPPLY_LEVEL_CODE_O(code),
        .DIO_OE_O(dio_oe), .DIO_OUT_O(dio_out)
    );

    rsp_host i_rsp_host (
        .clk_i(clk), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo), .oe_i(oe)
    );

    // ****************************************
    // Register store behind the port
    // ****************************************
    always @(posedge clk) begin
        // 0x7FE never answers, 0x7FF answers with a refusal
        rd_valid <= rd_req && rd_addr != 11'h7FE;
        rd_err   <= rd_addr == 11'h7FF;
        rd_data  <= {21'h0, rd_addr} ^ 32'hC3C30000;
        if (wr_valid && wr_rdy) begin
            last_wr <= wr;
            nwr     <= nwr + 1;
        end
        nsr  <= nsr + int'(srst);
        nref <= nref + int'(ref_p);
        nls  <= nls + int'(ls);
    end

    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic x(input logic [10:0] a, input logic rd, input logic [31:0] d,
                     input int n = 64, input logic bad = 1'b0);
        logic [63:0] r;
        i_rsp_host.frame(a, rd, d, n, bad, r);
        st = r[39:32];
        q  = r[31:0];
        repeat (12) @(posedge clk);
        chk("spar", 64'h0, {63'h0, ^st});
        chk("oe", 64'h0, {63'h0, oe});
    endtask : x

    task automatic test_done;
        if (failures == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        #(40000 * 50);
        failures++;
        test_done();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        chk("int_n", 64'h0, {63'h0, int_n});
        chk("dio_oe", 64'h0, {60'h0, dio_oe});
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        x(`RSP_ADDR_MSTAT, 1'b1, 32'h0);
        chk("freset", 64'h1, {63'h0, q[0]});
        x(11'h155, 1'b0, 32'h80000001);
        chk("wr", {11'h155, 32'h80000001}, last_wr);
        x(11'h2AA, 1'b1, 32'h0);
        chk("rd", 64'hC3C302AA, {32'h0, q});
        chk("dpar wr", 64'h0, {63'h0, st[4]});
        x(11'h155, 1'b0, 32'h1, 64, 1'b1);
        chk("dpar rd", 64'h1, {63'h0, st[4]});
        x(`RSP_ADDR_MSTAT, 1'b1, 32'h0);
        chk("mis", 64'h1, {63'h0, st[3]});
        chk("nwr", 64'h1, 64'(nwr));
        for (int i = 0; i < 4; i++) begin
            x(11'h155, i >= 2, 32'h5, lens[i]);
            if (i > 0) chk("badclk", 64'h1, {63'h0, st[1]});
        end
        chk("nwr len", 64'h1, 64'(nwr));
        x(11'h7FF, 1'b1, 32'h0);
        x(11'h7FE, 1'b1, 32'h0);
        chk("rd err", 64'h1, {63'h0, st[0]});
        chk("unf q", 64'h0, {32'h0, q});
        x(`RSP_ADDR_CTRL, 1'b0, 32'h100);
        chk("unf", 64'h1, {63'h0, st[5]});
        lw = last_wr;
        x(11'h155, 1'b0, 32'h7);
        chk("safe", lw, last_wr);
        x(`RSP_ADDR_CTRL, 1'b0, 32'h3);
        chk("badaddr", 64'h1, {63'h0, st[0]});
        chk("dio", 64'h11, {56'h0, dio_oe, dio_out});
        x(11'h155, 1'b0, 32'h9);
        chk("unsafe", {11'h155, 32'h9}, last_wr);
        // Stalled consumer: two words buffered, the third is lost
        wr_rdy <= 1'b0;
        for (int i = 10; i < 13; i++) begin
            x(11'h155, 1'b0, 32'(i));
        end
        wr_rdy <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            warn <= (i > 0);
            low  <= (i > 1);
            repeat (8) @(posedge clk);
            chk("code", {62'h0, sup[i]}, {62'h0, code});
        end
        chk("ovf keep", {11'h155, 32'hB}, last_wr);
        x(`RSP_ADDR_MSTAT, 1'b0, 32'h3);
        chk("ovf", 64'h1, {63'h0, st[6]});
        chk("int clr", 64'h1, {63'h0, int_n});
        acc <= 1'b1;
        @(posedge clk);
        acc <= 1'b0;
        repeat (4) @(posedge clk);
        chk("int acc", 64'h0, {63'h0, int_n});
        x(`RSP_ADDR_MSTAT, 1'b1, 32'h0);
        chk("acc flag", 64'h1, {63'h0, q[1]});
        snap = nref;
        repeat (500) @(posedge clk);
        chk("refresh", 64'd10, 64'(nref - snap));
        snap = nls;
        x(`RSP_ADDR_RESET, 1'b0, `RSP_RESET_PATTERN);
        chk("soft rst", 64'h1, 64'(nsr));
        chk("load", 64'h1, 64'(nls - snap));
        chk("dio rst", 64'h0, {60'h0, dio_oe});
        test_done();
    end
endmodule : tb_top

`default_nettype wire
